// file: rtl/psc_pkg.sv
/*
 * Constants, field layout and carrier types of the PHY-specific control fields.
 * Assumes a station management front end that has already decoded the register address.
 */
package psc_pkg;

   // --------------------------------------------------------------
   // Field positions in the 16-bit register
   // --------------------------------------------------------------
   localparam int unsigned REG_W         = 16;
   localparam int unsigned SCR_BYP_BIT   = 11;
   localparam int unsigned LB_DEPTH_LSB  = 8;
   localparam int unsigned LB_DEPTH_MSB  = 9;
   localparam int unsigned FD_COL_BIT    = 4;
   localparam int unsigned INTERRUPT_POLARITY_BIT   = 3;
   localparam int unsigned TEST_INT_BIT  = 2;
   localparam int unsigned INT_EN_BIT    = 1;
   localparam int unsigned INT_OE_BIT    = 0;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic       SCR_BYP_RST  = 1'h0;
   localparam logic [1:0] LB_DEPTH_RST = 2'h1;
   localparam logic       FD_COL_RST   = 1'h0;
   localparam logic       INTERRUPT_POLARITY_RST  = 1'h1;
   localparam logic       TEST_INT_RST = 1'h0;
   localparam logic       INT_EN_RST   = 1'h0;
   localparam logic       INT_OE_RST   = 1'h0;

   // --------------------------------------------------------------
   // Loopback elastic buffer
   // --------------------------------------------------------------
   localparam int unsigned NIB_W      = 4;
   localparam int unsigned LB_MAX_NIB = 8;
   localparam int unsigned LB_PTR_W   = 3;
   localparam int unsigned LB_CNT_W   = 4;
   localparam logic [1:0]  LB_CODE_4  = 2'h0;
   localparam logic [1:0]  LB_CODE_5  = 2'h1;
   localparam logic [1:0]  LB_CODE_6  = 2'h2;
   localparam logic [3:0]  LB_NIB_4   = 4'h4;
   localparam logic [3:0]  LB_NIB_5   = 4'h5;
   localparam logic [3:0]  LB_NIB_6   = 4'h6;
   localparam logic [3:0]  LB_NIB_8   = 4'h8;

   typedef struct packed {
      logic       scr_bypass;
      logic [1:0] lb_depth;
      logic       full_duplex_collision_enable;
      logic       interrupt_polarity;
      logic       test_int;
      logic       int_en;
      logic       int_oe;
   } psc_ctrl_t;

   localparam psc_ctrl_t CTRL_RST = '{SCR_BYP_RST, LB_DEPTH_RST, FD_COL_RST,
                                      INTERRUPT_POLARITY_RST, TEST_INT_RST, INT_EN_RST, INT_OE_RST};

   typedef struct packed {
      logic       valid;
      logic [3:0] data;
   } psc_nib_t;

   typedef enum logic [0:0] {
      LB_FILL = 1'b0,
      LB_RUN  = 1'b1
   } psc_lb_state_t;

   function automatic logic [3:0] psc_depth_nib(input logic [1:0] code);
      logic [3:0] n;
      n = LB_NIB_8;
      if (code == LB_CODE_4) n = LB_NIB_4;
      else if (code == LB_CODE_5) n = LB_NIB_5;
      else if (code == LB_CODE_6) n = LB_NIB_6;
      return n;
   endfunction : psc_depth_nib

endpackage : psc_pkg

// file: rtl/psc_elastic_fifo.sv
/*
 * Far-end loopback elastic buffer: nibbles from the receive side, drained on transmit ticks.
 * Assumes receive strobes and transmit ticks are already on clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module psc_elastic_fifo
   import psc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [3:0] depth_nib_in,
   input  wire psc_nib_t   rx_in,
   input  wire logic       tx_tick_in,
   output psc_nib_t        tx_out,
   output logic            overflow_out,
   output logic            underflow_out
);

   logic [NIB_W-1:0]    mem_q [LB_MAX_NIB];
   logic [LB_PTR_W-1:0] wr_ptr_q;
   logic [LB_PTR_W-1:0] rd_ptr_q;
   logic [LB_CNT_W-1:0] cnt_q;
   psc_lb_state_t       state_q;
   logic                do_wr;
   logic                do_rd;

   // Full buffer drops the new nibble rather than corrupting old ones
   assign do_wr = rx_in.valid && (cnt_q != LB_CNT_W'(LB_MAX_NIB));
   assign do_rd = tx_tick_in && (state_q == LB_RUN) && (cnt_q != '0);

   // --------------------------------------------------------------
   // Storage and pointers
   // --------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem_q[wr_ptr_q] <= rx_in.data; // RL3
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         if (do_wr) wr_ptr_q <= wr_ptr_q + 1'h1;
         if (do_rd) rd_ptr_q <= rd_ptr_q + 1'h1;
         cnt_q <= cnt_q + LB_CNT_W'(do_wr) - LB_CNT_W'(do_rd);
      end
   end

   // --------------------------------------------------------------
   // Preload then stream; a transmit tick on an empty buffer restarts the preload
   // --------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= LB_FILL;
      end else begin
         unique case (state_q)
            LB_FILL: if (cnt_q >= depth_nib_in) state_q <= LB_RUN; // RL2
            LB_RUN:  if (tx_tick_in && cnt_q == '0) state_q <= LB_FILL;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_out        <= '0;
         overflow_out  <= 1'h0;
         underflow_out <= 1'h0;
      end else begin
         tx_out.valid  <= do_rd;
         tx_out.data   <= do_rd ? mem_q[rd_ptr_q] : tx_out.data; // RL3
         overflow_out  <= rx_in.valid && !do_wr;
         underflow_out <= tx_tick_in && (state_q == LB_RUN) && (cnt_q == '0);
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   fifo_count_bound_a: assert property (cnt_q <= LB_CNT_W'(LB_MAX_NIB)) // RL3
      else $error("loopback count above capacity");
   preload_depth_a: assert property (state_q == LB_FILL && $past(state_q) == LB_FILL
                                     |-> $past(cnt_q) < $past(depth_nib_in)) // RL2
      else $error("fill state held past selected depth");
   read_in_order_a: assert property (do_rd |=> tx_out.valid && tx_out.data == $past(mem_q[rd_ptr_q])) // RL3
      else $error("loopback nibble not delivered in order");
   run_cover_c: cover property (state_q == LB_FILL ##1 state_q == LB_RUN);
   overflow_cover_c: cover property (overflow_out);

endmodule : psc_elastic_fifo

`default_nettype wire

// file: rtl/psc_phy_ctrl.sv
/*
 * PHY-specific control fields: storage, readback and the logic the fields steer.
 * Assumes the management front end gives a one-cycle write strobe for this register,
 * and that duplex, collision, event and loopback inputs are already on clk_in.
 */
// Behaviour
// (RL1) A one in the scrambler bypass field skips the 100 Mb/s scrambler and descrambler; zero keeps them.
// (RL2) The two-bit loopback depth field picks 4, 5, 6 or 8 nibbles for codes 00, 01, 10 and 11.
// (RL3) The loopback elastic buffer takes receive nibbles and hands them out on transmit ticks.
// (RL4) After reset the loopback depth field reads 01, a five-nibble buffer.
// (RL5) Software picks the depth from packet size and clock accuracy so the buffer never runs over or dry.
// (RL6) A one in the full-duplex collision enable field lets collision show in full duplex; it resets to zero.
// (RL7) With that field at zero collision shows only in half duplex.
// (RL8) Interrupt polarity one, the reset value, idles the interrupt high and pulls it low when active; zero is the reverse.
// (RL9) A one in the test interrupt field forces the interrupt active; it resets to zero.
// (RL10) Event status keeps being recorded while a test interrupt is forced.
// (RL11) Bits 10 and 7 to 5 ignore writes and read as zero.
// (RL12) Event interrupts reach the output only while the interrupt enable bit is one.
// (RL13) The shared pin drives an interrupt only while interrupt output enable is one, else it is a power-down input.
`timescale 1ns/1ps
`default_nettype none

module psc_phy_ctrl
   import psc_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             reg_wr_in,
   input  wire logic [REG_W-1:0] reg_wdata_in,
   output logic      [REG_W-1:0] reg_rdata_out,
   output logic                  scrambler_bypass_out,
   input  wire logic             full_duplex_in,
   input  wire logic             collision_raw_in,
   output logic                  collision_out,
   input  wire logic             event_in,
   input  wire logic             event_clr_in,
   output logic                  event_status_out,
   input  wire logic             interrupt_powerdown_pin_in,
   output logic                  interrupt_powerdown_pin_out,
   output logic                  interrupt_powerdown_pin_oe_out,
   output logic                  powerdown_out,
   input  wire psc_nib_t         lb_rx_in,
   input  wire logic             lb_tx_tick_in,
   output psc_nib_t              lb_tx_out,
   output logic                  lb_overflow_out,
   output logic                  lb_underflow_out
);

   psc_ctrl_t ctrl_q;
   psc_ctrl_t ctrl_d;
   logic      event_q;
   logic      irq_active;
   logic      pin_meta_q;
   logic      pin_sync_q;

   // --------------------------------------------------------------
   // Control field storage
   // --------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      if (reg_wr_in) begin
         ctrl_d.scr_bypass                   = reg_wdata_in[SCR_BYP_BIT];
         ctrl_d.lb_depth                     = reg_wdata_in[LB_DEPTH_MSB:LB_DEPTH_LSB];
         ctrl_d.full_duplex_collision_enable = reg_wdata_in[FD_COL_BIT];
         ctrl_d.interrupt_polarity           = reg_wdata_in[INTERRUPT_POLARITY_BIT];
         ctrl_d.test_int                     = reg_wdata_in[TEST_INT_BIT];
         ctrl_d.int_en                       = reg_wdata_in[INT_EN_BIT];
         ctrl_d.int_oe                       = reg_wdata_in[INT_OE_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= CTRL_RST; // RL4
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Readback is combinational so a read in the write's next cycle sees new data
   always_comb begin
      reg_rdata_out                             = '0; // RL11
      reg_rdata_out[SCR_BYP_BIT]                = ctrl_q.scr_bypass;
      reg_rdata_out[LB_DEPTH_MSB:LB_DEPTH_LSB]  = ctrl_q.lb_depth;
      reg_rdata_out[FD_COL_BIT]                 = ctrl_q.full_duplex_collision_enable;
      reg_rdata_out[INTERRUPT_POLARITY_BIT]                = ctrl_q.interrupt_polarity;
      reg_rdata_out[TEST_INT_BIT]               = ctrl_q.test_int;
      reg_rdata_out[INT_EN_BIT]                 = ctrl_q.int_en;
      reg_rdata_out[INT_OE_BIT]                 = ctrl_q.int_oe;
   end

   // --------------------------------------------------------------
   // Datapath steering
   // --------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         scrambler_bypass_out <= 1'h0;
         collision_out        <= 1'h0;
      end else begin
         scrambler_bypass_out <= ctrl_q.scr_bypass; // RL1
         collision_out        <= collision_raw_in &&
                                 (!full_duplex_in || ctrl_q.full_duplex_collision_enable); // RL6 RL7
      end
   end

   // --------------------------------------------------------------
   // Event status and interrupt pin
   // --------------------------------------------------------------
   // Set beats clear so an event landing on the clear cycle survives
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         event_q <= 1'h0;
      end else begin
         event_q <= event_in || (event_q && !event_clr_in); // RL10
      end
   end
   assign event_status_out = event_q;

   assign irq_active = ctrl_q.test_int || (ctrl_q.int_en && event_q); // RL9 RL12

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         interrupt_powerdown_pin_out    <= INTERRUPT_POLARITY_RST;
         interrupt_powerdown_pin_oe_out <= 1'h0;
      end else begin
         interrupt_powerdown_pin_out    <= ctrl_q.interrupt_polarity ? !irq_active : irq_active; // RL8
         interrupt_powerdown_pin_oe_out <= ctrl_q.int_oe; // RL13
      end
   end

   // Pin is asynchronous; only the second stage is looked at
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_meta_q <= 1'h1;
         pin_sync_q <= 1'h1;
      end else begin
         pin_meta_q <= interrupt_powerdown_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         powerdown_out <= 1'h0;
      end else begin
         powerdown_out <= !ctrl_q.int_oe && !pin_sync_q; // RL13
      end
   end

   // --------------------------------------------------------------
   // Far-end loopback buffer
   // --------------------------------------------------------------
   // Depth is taken live; changing it mid-frame only moves the next preload point
   psc_elastic_fifo u_lb_fifo (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .depth_nib_in  (psc_depth_nib(ctrl_q.lb_depth)), // RL2
      .rx_in         (lb_rx_in),
      .tx_tick_in    (lb_tx_tick_in),
      .tx_out        (lb_tx_out),
      .overflow_out  (lb_overflow_out),
      .underflow_out (lb_underflow_out)
   );

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking

   reset_depth_a: assert property (!sys_rst_in && $past(sys_rst_in) && !reg_wr_in |->
                                   reg_rdata_out[LB_DEPTH_MSB:LB_DEPTH_LSB] == LB_CODE_5) // RL4
      else $error("depth field not 01 after reset");
   reserved_zero_a: assert property (disable iff (sys_rst_in)
                                     reg_rdata_out[10] == 1'h0 && reg_rdata_out[7:5] == 3'h0) // RL11
      else $error("reserved bits read non-zero");
   write_readback_a: assert property (disable iff (sys_rst_in)
                                      reg_wr_in |=> reg_rdata_out == ($past(reg_wdata_in) & 16'h0B1F)) // RL2
      else $error("written fields not read back");
   scr_bypass_a: assert property (disable iff (sys_rst_in)
                                  reg_wr_in |-> ##2 scrambler_bypass_out == $past(reg_wdata_in[SCR_BYP_BIT], 2)) // RL1
      else $error("scrambler bypass does not follow field");
   fd_collision_a: assert property (disable iff (sys_rst_in)
                                    full_duplex_in && !ctrl_q.full_duplex_collision_enable |=> !collision_out) // RL7
      else $error("collision shown in full duplex while disabled");
   fd_col_enable_a: assert property (disable iff (sys_rst_in)
                                     collision_raw_in && ctrl_q.full_duplex_collision_enable |=> collision_out) // RL6
      else $error("enabled collision not shown");
   test_int_a: assert property (disable iff (sys_rst_in)
                                ctrl_q.test_int |=> interrupt_powerdown_pin_out != $past(ctrl_q.interrupt_polarity)) // RL9
      else $error("test interrupt not forcing active level");
   idle_level_a: assert property (disable iff (sys_rst_in)
                                  !ctrl_q.test_int && !(ctrl_q.int_en && event_q)
                                  |=> interrupt_powerdown_pin_out == $past(ctrl_q.interrupt_polarity)) // RL8 RL12
      else $error("interrupt pin not at idle level");
   event_kept_a: assert property (disable iff (sys_rst_in)
                                  event_in && ctrl_q.test_int |=> event_status_out) // RL10
      else $error("event lost while test interrupt forced");
   pin_enable_a: assert property (disable iff (sys_rst_in)
                                  !ctrl_q.int_oe |=> !interrupt_powerdown_pin_oe_out) // RL13
      else $error("pin driven while used as power-down input");
   pin_drive_a: assert property (disable iff (sys_rst_in)
                                 ctrl_q.int_oe |=> interrupt_powerdown_pin_oe_out && !powerdown_out) // RL13
      else $error("pin not driven as interrupt output");
   half_duplex_col_a: assert property (disable iff (sys_rst_in)
                                       !full_duplex_in && collision_raw_in |=> collision_out) // RL7
      else $error("collision not shown in half duplex");
   event_set_a: assert property (disable iff (sys_rst_in) event_in |=> event_status_out) // RL10
      else $error("event not recorded");
   event_clear_a: assert property (disable iff (sys_rst_in)
                                   event_clr_in && !event_in |=> !event_status_out) // RL10
      else $error("event status not cleared");
   event_irq_a: assert property (disable iff (sys_rst_in)
                                 ctrl_q.int_en && event_q
                                 |=> interrupt_powerdown_pin_out != $past(ctrl_q.interrupt_polarity)) // RL12
      else $error("enabled event not shown on interrupt pin");

   fd_col_cover_c: cover property (disable iff (sys_rst_in) full_duplex_in && collision_out);
   test_int_cover_c: cover property (disable iff (sys_rst_in) ctrl_q.test_int && ctrl_q.int_oe);
   pwdn_cover_c: cover property (disable iff (sys_rst_in) powerdown_out);

endmodule : psc_phy_ctrl

`default_nettype wire

// file: verification/psc_host_model.sv
/* Station management host stand-in that writes the PHY-specific control register.
   Assumes the front end has decoded the address and wants a one-cycle write strobe. */
`timescale 1ns/1ps
`default_nettype none

module psc_host_model
   import psc_pkg::*;
(
   input  wire logic             clk_in,
   output logic                  reg_wr_out,
   output logic      [REG_W-1:0] reg_wdata_out
);
   initial begin
      reg_wr_out    = 1'b0;
      reg_wdata_out = 16'h0000;
   end

   // Caller picks the loopback depth to suit its packet size and clock error
   task automatic write_reg(input logic [REG_W-1:0] data);
      @(posedge clk_in);
      reg_wr_out    <= 1'b1;
      reg_wdata_out <= data;
      @(posedge clk_in);
      reg_wr_out    <= 1'b0;
      // Stale data would hide a missing strobe qualifier
      reg_wdata_out <= ~data;
   endtask : write_reg
endmodule : psc_host_model

`default_nettype wire

// file: verification/psc_phy_ctrl_tb.sv
/* Self-checking bench for the PHY-specific control fields.
   Assumes psc_pkg and the design files are compiled first; one 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none

module psc_phy_ctrl_tb
   import psc_pkg::*;
;
   logic             clk_in     = 1'b0;
   logic             sys_rst_in = 1'b1;
   logic             reg_wr;
   logic [REG_W-1:0] reg_wdata;
   logic [REG_W-1:0] rdata;
   logic             scr_byp, fd, col_raw, col, ev, ev_clr, ev_st;
   logic             pin_in, pin_out, pin_oe, pdn, tick, ovf, unf;
   psc_nib_t         rx, tx;
   int               n_fail     = 0;
   int               num_checks = 0;

   always #5 clk_in = ~clk_in;

   psc_host_model i_psc_host_model (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata));

   psc_phy_ctrl i_psc_phy_ctrl (
      .clk_in                        (clk_in),
      .sys_rst_in                    (sys_rst_in),
      .reg_wr_in                     (reg_wr),
      .reg_wdata_in                  (reg_wdata),
      .reg_rdata_out                 (rdata),
      .scrambler_bypass_out          (scr_byp),
      .full_duplex_in                (fd),
      .collision_raw_in              (col_raw),
      .collision_out                 (col),
      .event_in                      (ev),
      .event_clr_in                  (ev_clr),
      .event_status_out              (ev_st),
      .interrupt_powerdown_pin_in    (pin_in),
      .interrupt_powerdown_pin_out   (pin_out),
      .interrupt_powerdown_pin_oe_out(pin_oe),
      .powerdown_out                 (pdn),
      .lb_rx_in                      (rx),
      .lb_tx_tick_in                 (tick),
      .lb_tx_out                     (tx),
      .lb_overflow_out               (ovf),
      .lb_underflow_out              (unf)
   );

   // ----------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_cyc

   task automatic wr(input logic [15:0] d);
      i_psc_host_model.write_reg(d);
      #1;
   endtask : wr

   task automatic nib(input logic [3:0] d);
      @(posedge clk_in);
      rx <= '{1'b1, d};
      @(posedge clk_in);
      rx <= '0;
      #1;
   endtask : nib

   task automatic tk();
      @(posedge clk_in);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
      #1;
   endtask : tk

   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_reset();
      check("rdata", 16'h0108, rdata);
      check("pin_out", 16'h0001, pin_out);
      check("pin_oe", 16'h0000, pin_oe);
   endtask : t_reset

   task automatic t_fields();
      wr(16'hFFFF);
      check("rdata", 16'h0B1F, rdata);
      wait_cyc(1);
      check("bypass", 16'h0001, scr_byp);
      wr(16'hF4E0);
      check("rdata", 16'h0000, rdata);
      wait_cyc(1);
      check("bypass", 16'h0000, scr_byp);
   endtask : t_fields

   task automatic t_collision();
      for (int i = 0; i < 4; i++) begin
         wr({11'h000, i[1], 4'h8});
         @(posedge clk_in);
         fd      <= i[0];
         col_raw <= 1'b1;
         wait_cyc(2);
         check("collision", {15'h0000, !i[0] || i[1]}, col);
         col_raw <= 1'b0;
         wait_cyc(2);
      end
   endtask : t_collision

   task automatic t_interrupt();
      wr(16'h000D);
      wait_cyc(2);
      check("pin_oe", 16'h0001, pin_oe);
      check("pin_out", 16'h0000, pin_out);
      wr(16'h0005);
      wait_cyc(2);
      check("pin_out", 16'h0001, pin_out);
      @(posedge clk_in);
      ev <= 1'b1;
      @(posedge clk_in);
      ev <= 1'b0;
      wait_cyc(1);
      check("event_status", 16'h0001, ev_st);
      wr(16'h0009);
      wait_cyc(2);
      check("pin_out", 16'h0001, pin_out);
      wr(16'h000B);
      wait_cyc(2);
      check("pin_out", 16'h0000, pin_out);
      @(posedge clk_in);
      ev_clr <= 1'b1;
      pin_in <= 1'b0;
      @(posedge clk_in);
      ev_clr <= 1'b0;
      wait_cyc(5);
      check("event_status", 16'h0000, ev_st);
      check("pin_out", 16'h0001, pin_out);
      check("powerdown", 16'h0000, pdn);
      wr(16'h0008);
      wait_cyc(5);
      check("pin_oe", 16'h0000, pin_oe);
      check("powerdown", 16'h0001, pdn);
      @(posedge clk_in);
      pin_in <= 1'b1;
      wait_cyc(5);
      check("powerdown", 16'h0000, pdn);
   endtask : t_interrupt

   task automatic t_loopback();
      int n;
      for (int code = 0; code < 4; code++) begin
         n = (code == 3) ? 8 : code + 4;
         wr({6'h00, code[1:0], 8'h08});
         for (int i = 0; i < n - 1; i++) nib(i[3:0]);
         wait_cyc(2);
         tk();
         check("tx_valid", 16'h0000, tx.valid);
         nib(4'(n - 1));
         if (code == 3) begin
            // Ninth nibble must be dropped, not stored
            nib(4'hF);
            check("overflow", 16'h0001, ovf);
         end
         wait_cyc(2);
         for (int i = 0; i < n; i++) begin
            tk();
            check("tx_valid", 16'h0001, tx.valid);
            check("tx_data", 16'(i), tx.data);
         end
         tk();
         check("underflow", 16'h0001, unf);
      end
   endtask : t_loopback

   // ----------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      {fd, col_raw, ev, ev_clr, tick} = '0;
      pin_in = 1'b1;
      rx     = '0;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      #1;
      t_reset();
      t_fields();
      t_collision();
      t_interrupt();
      t_loopback();
      summarize();
   end

   // Whole run is well under 2000 cycles
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
endmodule : psc_phy_ctrl_tb

`default_nettype wire
